// ---- rtl/ctm_pkg.sv ----
package ctm_pkg;
  localparam logic [7:0] CTM_OFS_CTRL0   = 8'h00;
  localparam logic [7:0] CTM_OFS_CTRL1   = 8'h04;
  localparam logic [7:0] CTM_OFS_CNT_LO  = 8'h08;
  localparam logic [7:0] CTM_OFS_CNT_HI  = 8'h0c;
  localparam logic [7:0] CTM_OFS_A_LO    = 8'h10;
  localparam logic [7:0] CTM_OFS_A_HI    = 8'h14;
  localparam logic [7:0] CTM_OFS_FLAGS   = 8'h18;
  localparam logic [7:0] CTM_RST_CTRL0   = 8'h00;
  localparam logic [7:0] CTM_RST_CTRL1   = 8'h00;
  localparam int CTM_BIT_PAUSE  = 7;
  localparam int CTM_POS_CKSEL  = 4;
  localparam int CTM_BIT_RUN    = 3;
  localparam int CTM_POS_PERIOD = 0;
  localparam int CTM_POS_MODE   = 6;
  localparam int CTM_POS_PINFN  = 4;
  localparam int CTM_BIT_OC     = 3;
  localparam int CTM_BIT_POL    = 2;
  localparam int CTM_BIT_DPX    = 1;
  localparam int CTM_BIT_CCLR   = 0;
  localparam logic [1:0] CTM_MODE_CMP = 2'h0;
  localparam logic [1:0] CTM_MODE_PWM = 2'h2;
  localparam logic [1:0] CTM_MODE_TMR = 2'h3;
  localparam logic [1:0] CTM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CTM_RESP_SLVERR = 2'h2;
  localparam int CTM_DIV_SYS4  = 4;
  localparam int CTM_DIV_H16   = 16;
  localparam int CTM_DIV_H64   = 64;
endpackage

// ---- rtl/ctm_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module ctm_timer
  import ctm_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_high,
  input  wire logic        clk_sub,
  input  wire logic        external_clock_pin,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             timer_output_pin,
  output logic             complementary_output_pin,
  output logic             match_a_flag,
  output logic             match_p_flag
);
  // Registers
  logic [7:0]       timer_control_zero;
  logic [7:0]       timer_control_one;
  logic [CNT_W-1:0] compare_a_value;
  logic [7:0]       low_buffer;
  logic [CNT_W-1:0] count;
  logic             run_q;
  logic             pin_level;
  logic [5:0]       presc;
  logic [2:0]       hi_sync;
  logic [2:0]       sub_sync;
  logic [2:0]       ext_sync;
  // AXI state
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire       pause_bit          = timer_control_zero[CTM_BIT_PAUSE];
  wire [2:0] clock_select       = timer_control_zero[CTM_POS_CKSEL +: 3];
  wire       run_enable         = timer_control_zero[CTM_BIT_RUN];
  wire [2:0] period_value       = timer_control_zero[CTM_POS_PERIOD +: 3];
  wire [1:0] mode_field         = timer_control_one[CTM_POS_MODE +: 2];
  wire [1:0] pin_function_field = timer_control_one[CTM_POS_PINFN +: 2];
  wire       output_control_bit = timer_control_one[CTM_BIT_OC];
  wire       polarity_bit       = timer_control_one[CTM_BIT_POL];
  wire       duty_period_select = timer_control_one[CTM_BIT_DPX];
  wire       clear_select       = timer_control_one[CTM_BIT_CCLR];

  // Clock sources become one-cycle ticks; the link clocks are sampled, not used as clocks
  wire hi_rise  = hi_sync[1] & ~hi_sync[2];
  wire sub_rise = sub_sync[1] & ~sub_sync[2];
  wire ext_rise = ext_sync[1] & ~ext_sync[2];
  wire ext_fall = ~ext_sync[1] & ext_sync[2];
  logic [5:0] hi_cnt;
  wire sys4_tick = (presc[1:0] == 2'(CTM_DIV_SYS4 - 1));
  wire h16_tick  = hi_rise && (hi_cnt[3:0] == 4'(CTM_DIV_H16 - 1));
  wire h64_tick  = hi_rise && (hi_cnt == 6'(CTM_DIV_H64 - 1));
  logic tick;
  always_comb begin
    case (clock_select)
      3'h0:    tick = sys4_tick;
      3'h1:    tick = 1'b1;
      3'h2:    tick = h16_tick;
      3'h3:    tick = h64_tick;
      3'h4,
      3'h5:    tick = sub_rise;
      3'h6:    tick = ext_rise;
      default: tick = ext_fall;
    endcase
  end

  // Comparators
  wire [CNT_W-1:0] next_count_raw = count + 1'b1;
  wire step      = run_enable && !pause_bit && tick;
  wire is_pwm    = (mode_field == CTM_MODE_PWM);
  wire p_hit     = step && (period_value != 3'h0) &&
                   (next_count_raw[CNT_W-1 -: 3] == period_value);
  wire ovf       = step && (count == {CNT_W{1'b1}});
  wire a_hit     = step && (next_count_raw == compare_a_value) &&
                   (compare_a_value != '0);
  // PWM ignores clear_select; duty_period_select picks the wrap: compare A when set, else the period comparator
  wire p_clear   = p_hit || (ovf && period_value == 3'h0);
  wire a_clear   = a_hit || (ovf && compare_a_value == '0);
  wire clr_by_a  = is_pwm ? duty_period_select : clear_select;
  wire cnt_clear = clr_by_a ? a_clear : p_clear;
  wire set_a     = a_hit;
  wire set_p     = p_hit && !(clear_select && !is_pwm);
  wire run_rise  = run_enable && !run_q;

  // Compare mode pin action
  logic next_pin;
  always_comb begin
    next_pin = pin_level;
    if (run_rise) begin
      next_pin = output_control_bit;
    end else if (mode_field == CTM_MODE_CMP && set_a) begin
      case (pin_function_field)
        2'h1:    next_pin = 1'b0;
        2'h2:    next_pin = 1'b1;
        2'h3:    next_pin = ~pin_level;
        default: next_pin = pin_level;
      endcase
    end
  end

  // PWM waveform: active while count below duty
  wire [CNT_W-1:0] p_full = (period_value == 3'h0) ? {CNT_W{1'b1}} :
                            {period_value, {(CNT_W-3){1'b0}}};
  wire [CNT_W-1:0] duty   = duty_period_select ? p_full : compare_a_value;
  wire pwm_on             = (count < duty);
  logic pwm_level;
  always_comb begin
    case (pin_function_field)
      2'h0:    pwm_level = ~output_control_bit;
      2'h1:    pwm_level = output_control_bit;
      2'h2:    pwm_level = pwm_on ? output_control_bit : ~output_control_bit;
      default: pwm_level = ~output_control_bit;
    endcase
  end
  // Timer/counter mode leaves the pin at its last level
  wire pin_raw  = is_pwm ? pwm_level : pin_level;
  wire pin_out  = (mode_field == CTM_MODE_TMR) ? timer_output_pin :
                  (pin_raw ^ polarity_bit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc    <= '0;
      hi_cnt   <= '0;
      hi_sync  <= '0;
      sub_sync <= '0;
      ext_sync <= '0;
    end else begin
      presc    <= presc + 1'b1;
      hi_sync  <= {hi_sync[1:0], clk_high};
      sub_sync <= {sub_sync[1:0], clk_sub};
      ext_sync <= {ext_sync[1:0], external_clock_pin};
      if (hi_rise) begin
        hi_cnt <= hi_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count     <= '0;
      run_q     <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      run_q     <= run_enable;
      pin_level <= next_pin;
      if (run_rise) begin
        count <= '0;
      end else if (step) begin
        count <= cnt_clear ? '0 : next_count_raw;
      end
    end
  end

  // AXI4-Lite slave
  wire aw_ok     = aw_held || s_axi_awvalid;
  wire w_ok      = w_held || s_axi_wvalid;
  wire do_write  = aw_ok && w_ok && !s_axi_bvalid;
  wire [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire        we0 = w_held ? w_strb[0] : s_axi_wstrb[0];
  wire wr_c0  = do_write && we0 && (wa == CTM_OFS_CTRL0);
  wire wr_c1  = do_write && we0 && (wa == CTM_OFS_CTRL1);
  wire wr_alo = do_write && we0 && (wa == CTM_OFS_A_LO);
  wire wr_ahi = do_write && we0 && (wa == CTM_OFS_A_HI);
  wire wr_map = (wa == CTM_OFS_CTRL0) || (wa == CTM_OFS_CTRL1) ||
                (wa == CTM_OFS_CNT_LO) || (wa == CTM_OFS_CNT_HI) ||
                (wa == CTM_OFS_A_LO) || (wa == CTM_OFS_A_HI) ||
                (wa == CTM_OFS_FLAGS);
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire rd_chi  = do_read && (s_axi_araddr == CTM_OFS_CNT_HI);
  wire rd_ahi  = do_read && (s_axi_araddr == CTM_OFS_A_HI);
  logic [31:0] rd_mux;
  logic        rd_bad;
  always_comb begin
    rd_bad = 1'b0;
    if (s_axi_araddr == CTM_OFS_CTRL0) begin
      rd_mux = {24'h0, timer_control_zero};
    end else if (s_axi_araddr == CTM_OFS_CTRL1) begin
      rd_mux = {24'h0, timer_control_one};
    end else if (s_axi_araddr == CTM_OFS_CNT_LO || s_axi_araddr == CTM_OFS_A_LO) begin
      rd_mux = {24'h0, low_buffer};
    end else if (s_axi_araddr == CTM_OFS_CNT_HI) begin
      rd_mux = {30'h0, count[CNT_W-1:8]};
    end else if (s_axi_araddr == CTM_OFS_A_HI) begin
      rd_mux = {30'h0, compare_a_value[CNT_W-1:8]};
    end else if (s_axi_araddr == CTM_OFS_FLAGS) begin
      rd_mux = {30'h0, match_p_flag, match_a_flag};
    end else begin
      rd_mux = 32'h0;
      rd_bad = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CTM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? CTM_RESP_OKAY : CTM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Readies come from flops: each mirrors what held/valid state will be after this edge
  wire next_aw_held = !do_write && (aw_held || (s_axi_awvalid && s_axi_awready));
  wire next_w_held  = !do_write && (w_held || (s_axi_wvalid && s_axi_wready));
  wire next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready  <= !next_w_held && !next_bvalid;
      s_axi_arready <= do_read ? 1'b0 : (s_axi_rvalid && s_axi_rready) ? 1'b1 : s_axi_arready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= CTM_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_bad ? CTM_RESP_SLVERR : CTM_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_zero <= CTM_RST_CTRL0;
      timer_control_one  <= CTM_RST_CTRL1;
      compare_a_value    <= '0;
      low_buffer         <= '0;
    end else begin
      if (wr_c0) begin
        timer_control_zero <= wd[7:0];
      end
      if (wr_c1) begin
        timer_control_one <= wd[7:0];
      end
      // One buffer serves both pairs, as the low bytes share it
      if (wr_alo) begin
        low_buffer <= wd[7:0];
      end else if (rd_chi) begin
        low_buffer <= count[7:0];
      end else if (rd_ahi) begin
        low_buffer <= compare_a_value[7:0];
      end
      if (wr_ahi) begin
        compare_a_value <= {wd[1:0], low_buffer};
      end
    end
  end

  // Flags: hardware set wins over software clear (write 1 to clear)
  wire clr_a = do_write && we0 && (wa == CTM_OFS_FLAGS) && wd[0];
  wire clr_p = do_write && we0 && (wa == CTM_OFS_FLAGS) && wd[1];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_a_flag             <= 1'b0;
      match_p_flag             <= 1'b0;
      timer_output_pin         <= 1'b0;
      complementary_output_pin <= 1'b1;
    end else begin
      match_a_flag             <= set_a || (match_a_flag && !clr_a);
      match_p_flag             <= set_p || (match_p_flag && !clr_p);
      timer_output_pin         <= pin_out;
      complementary_output_pin <= ~pin_out;
    end
  end

  chk_comp_pin_inverse: assert property (@(posedge aclk) disable iff (!aresetn)
    complementary_output_pin == ~timer_output_pin)
    else $error("complementary pin not inverse");
  chk_run_rise_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    run_rise |=> count == '0)
    else $error("count not zeroed on run rise");
  chk_pause_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (pause_bit && !run_rise) |=> count == $past(count))
    else $error("count moved while paused");
  chk_off_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !run_enable |=> count == $past(count))
    else $error("count moved while off");
  chk_no_p_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (clear_select && !is_pwm && !match_p_flag) |=> !match_p_flag)
    else $error("p flag set with clear select");
  chk_init_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_rise && mode_field == CTM_MODE_CMP) |=> ##1
      timer_output_pin == (output_control_bit ^ polarity_bit))
    else $error("initial level wrong");
  chk_step_inc: assert property (@(posedge aclk) disable iff (!aresetn)
    (step && !cnt_clear && !run_rise) |=> count == $past(count) + 1'b1)
    else $error("counter did not step");
  chk_clear_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (step && cnt_clear && !run_rise) |=> count == '0)
    else $error("counter not cleared on match");
  cov_a_match: cover property (@(posedge aclk) disable iff (!aresetn) set_a);
  cov_p_match: cover property (@(posedge aclk) disable iff (!aresetn) set_p);
  cov_pwm_out: cover property (@(posedge aclk) disable iff (!aresetn)
    is_pwm && pin_function_field == 2'h2 && $rose(timer_output_pin));
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ctm_pkg::*;
;
  logic        aclk, aresetn, clk_high, clk_sub, ext_pin, pin, pin_n, flag_a, flag_p;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, w;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          miscompares, checks_done, seed, j, k, n, av;

  ctm_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_high(clk_high), .clk_sub(clk_sub),
    .external_clock_pin(ext_pin), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer_output_pin(pin), .complementary_output_pin(pin_n), .match_a_flag(flag_a),
    .match_p_flag(flag_p)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Longest expected run is near 8000 cycles
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end

  task automatic print_verdict;
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check_range(input string nm, input int lo, input int hi, input logic [31:0] got);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // Complementary pin watched on every cycle out of reset
  always @(negedge aclk) begin
    if (aresetn === 1'b1) check("comp_pin", {31'h0, ~pin}, {31'h0, pin_n});
  end

  // An expected response of xx means either answer is acceptable
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                    input logic [1:0] er = CTM_RESP_OKAY);
    logic aw_go, w_go, b_go;
    logic [1:0] resp;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b_go = 1'b0;
    while (b_go !== 1'b1) begin
      @(negedge aclk);
      aw_go = s_axi_awvalid & s_axi_awready;
      w_go  = s_axi_wvalid & s_axi_wready;
      b_go  = s_axi_bvalid & s_axi_bready;
      resp  = s_axi_bresp;
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
      if (b_go) s_axi_bready <= 1'b0;
    end
    if (er !== 2'bxx) check("bresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = CTM_RESP_OKAY);
    logic ar_go, r_go;
    logic [1:0] resp;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    r_go = 1'b0;
    while (r_go !== 1'b1) begin
      @(negedge aclk);
      ar_go = s_axi_arvalid & s_axi_arready;
      r_go  = s_axi_rvalid & s_axi_rready;
      resp  = s_axi_rresp;
      d     = s_axi_rdata;
      @(posedge aclk);
      if (ar_go) s_axi_arvalid <= 1'b0;
      if (r_go) s_axi_rready <= 1'b0;
    end
    check("rresp", {30'h0, er}, {30'h0, resp});
  endtask

  // High byte first, so the low byte comes from the latched buffer
  task automatic rdc(input logic [7:0] hi_addr, output logic [31:0] d);
    logic [31:0] h, l;
    rd(hi_addr, h);
    rd(hi_addr - 8'h04, l);
    d = {22'h0, h[1:0], l[7:0]};
  endtask

  task automatic run(input logic p, input logic [2:0] ck, input logic on, input logic [2:0] per);
    wr(CTM_OFS_CTRL0, {24'h0, p, ck, on, per});
  endtask

  task automatic look(input int c);
    repeat (c) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic pulses(input int s, input int cnt);
    repeat (cnt) begin
      if (s < 4) clk_high <= 1'b1;
      else if (s < 6) clk_sub <= 1'b1;
      else ext_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      {clk_high, clk_sub, ext_pin} <= 3'h0;
      repeat (3) @(posedge aclk);
    end
  endtask

  function automatic logic [31:0] c1(input logic [1:0] m, input logic [1:0] io, input logic oc,
                                     input logic pol, input logic dpx, input logic cc);
    return {24'h0, m, io, oc, pol, dpx, cc};
  endfunction

  function automatic int ne(input int s);
    return (s == 0) ? 200 : (s == 1) ? 50 : (s == 2) ? 48 : (s == 3) ? 128 : 5;
  endfunction

  function automatic int dv(input int s);
    return (s == 0) ? CTM_DIV_SYS4 : (s == 2) ? CTM_DIV_H16 : (s == 3) ? CTM_DIV_H64 : 1;
  endfunction

  function automatic logic cmp_level(input int io, input logic oc);
    return (io == 0) ? oc : (io == 1) ? 1'b0 : (io == 2) ? 1'b1 : ~oc;
  endfunction

  initial begin
    seed = 32'h3d76;
    aresetn = 1'b0;
    {clk_high, clk_sub, ext_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTM_OFS_CTRL0, v);
    check("ctrl0_reset", {24'h0, CTM_RST_CTRL0}, v);
    rd(CTM_OFS_CTRL1, v);
    check("ctrl1_reset", {24'h0, CTM_RST_CTRL1}, v);
    rd(8'h1c, v, CTM_RESP_SLVERR);
    check("unmapped_rdata", 32'h0, v);
    wr(8'h20, 32'hff, 4'hf, CTM_RESP_SLVERR);
    wr(CTM_OFS_CTRL1, 32'hff, 4'h0);
    rd(CTM_OFS_CTRL1, v);
    check("strobe_off", 32'h0, v);
    wr(CTM_OFS_CNT_HI, 32'h3, 4'hf, 2'bxx);
    wr(CTM_OFS_CNT_LO, 32'h55, 4'hf, 2'bxx);
    rdc(CTM_OFS_CNT_HI, v);
    check("count_no_write", 32'h0, v);
    wr(CTM_OFS_CTRL1, c1(CTM_MODE_TMR, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
    for (k = 0; k < 8; k++) begin
      run(1'b0, k[2:0], 1'b0, 3'h0);
      run(1'b0, k[2:0], 1'b1, 3'h0);
      if (k < 2) repeat (ne(k)) @(posedge aclk);
      else pulses(k, ne(k));
      run(1'b0, k[2:0], 1'b0, 3'h0);
      rdc(CTM_OFS_CNT_HI, v);
      check_range("count_clk_sel", ne(k) / dv(k) - 1, ne(k) / dv(k) + (k < 2 ? 6 : 0), v);
    end
    look(20);
    rdc(CTM_OFS_CNT_HI, w);
    check("count_residue", v, w);
    run(1'b0, 3'h1, 1'b1, 3'h0);
    rdc(CTM_OFS_CNT_HI, v);
    check_range("count_restart", 0, 12, v);
    run(1'b1, 3'h1, 1'b1, 3'h0);
    rdc(CTM_OFS_CNT_HI, v);
    look(20);
    rdc(CTM_OFS_CNT_HI, w);
    check("count_paused", v, w);
    run(1'b0, 3'h1, 1'b1, 3'h0);
    look(30);
    rdc(CTM_OFS_CNT_HI, w);
    check_range("count_resume", v + 30, v + 48, w);
    run(1'b0, 3'h1, 1'b0, 3'h0);
    wr(CTM_OFS_FLAGS, 32'h3);
    n = 1 + ({$random(seed)} % 7);
    run(1'b0, 3'h1, 1'b1, n[2:0]);
    look(n * 128 - 16);
    check("p_flag_early", 32'h0, {31'h0, flag_p});
    look(32);
    check("p_flag_set", 32'h1, {31'h0, flag_p});
    rdc(CTM_OFS_CNT_HI, v);
    check_range("count_p_clear", 0, 45, v);
    run(1'b0, 3'h1, 1'b0, 3'h0);
    wr(CTM_OFS_FLAGS, 32'h3);
    run(1'b0, 3'h1, 1'b1, 3'h0);
    look(1040);
    check("p_flag_overflow", 32'h0, {31'h0, flag_p});
    rdc(CTM_OFS_CNT_HI, v);
    check_range("count_wrap", 8, 34, v);
    for (j = 0; j < 4; j++) begin
      av = 130 + ({$random(seed)} % 250);
      k = $random(seed);
      run(1'b0, 3'h1, 1'b0, 3'h1);
      wr(CTM_OFS_A_LO, {24'h0, av[7:0]});
      wr(CTM_OFS_A_HI, {30'h0, av[9:8]});
      rdc(CTM_OFS_A_HI, v);
      check("a_value", av, v);
      wr(CTM_OFS_CTRL1, c1(CTM_MODE_CMP, j[1:0], k[0], k[1], 1'b0, 1'b1));
      wr(CTM_OFS_FLAGS, 32'h3);
      run(1'b0, 3'h1, 1'b1, 3'h1);
      look(2);
      check("pin_initial", {31'h0, k[0] ^ k[1]}, {31'h0, pin});
      look(av + 4);
      check("pin_match", {31'h0, cmp_level(j, k[0]) ^ k[1]}, {31'h0, pin});
      check("a_flag", 32'h1, {31'h0, flag_a});
      check("p_flag_masked", 32'h0, {31'h0, flag_p});
      rdc(CTM_OFS_CNT_HI, v);
      check_range("count_a_clear", 0, av, v);
    end
    for (j = 0; j < 10; j++) begin
      run(1'b0, 3'h1, 1'b0, 3'h1);
      wr(CTM_OFS_A_LO, (j == 9) ? 32'h40 : 32'h20);
      wr(CTM_OFS_A_HI, 32'h0);
      wr(CTM_OFS_CTRL1, c1(CTM_MODE_PWM, (j < 8) ? {1'b0, j[0]} : 2'h2, (j < 8) ? j[1] : 1'b1,
                           (j < 8) ? j[2] : 1'b0, j == 9, 1'b0));
      run(1'b0, 3'h1, 1'b1, 3'h1);
      look(20);
      n = 0;
      repeat (128) begin
        @(negedge aclk);
        n += (pin === 1'b1);
      end
      if (j < 8) check_range("pwm_forced", (j[0] ^ j[1] ^ j[2]) ? 0 : 128,
                             (j[0] ^ j[1] ^ j[2]) ? 0 : 128, n);
      else check_range("pwm_active", (j == 9) ? 126 : 30, (j == 9) ? 128 : 34, n);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
